// file: common/hmd_pkg.sv
// Constants, offsets and carrier types for the host mailbox decode block
package hmd_pkg;
	// Fixed host address of channels 1 and 2, bits 15 to 4
	localparam logic [11:0] FIXED_HI      = 12'h006;
	// Slave register offsets
	localparam logic [4:0]  OFF_CH_STRIDE = 5'h04;
	localparam logic [4:0]  OFF_CH_LAST   = 5'h0b;
	localparam logic [1:0]  SUB_IN_BYTE   = 2'h0;
	localparam logic [1:0]  SUB_OUT_BYTE  = 2'h1;
	localparam logic [1:0]  SUB_STATUS    = 2'h2;
	localparam logic [4:0]  OFF_BASE_HIGH = 5'h0c;
	localparam logic [4:0]  OFF_BASE_LOW  = 5'h0d;
	localparam logic [4:0]  OFF_CTRL      = 5'h0e;
	localparam logic [4:0]  OFF_SHARED    = 5'h10;
	// Field positions
	localparam int          OBF_BIT       = 0;
	localparam int          IBF_BIT       = 1;
	localparam int          SEL_BIT       = 2;
	localparam int          CD_BIT        = 3;
	localparam int          HOST_OWN_BIT  = 4;
	localparam int          SLAVE_OWN_BIT = 6;
	localparam int          SHR_EN_BIT    = 0;
	localparam int          CH3_EN_BIT    = 0;
	// Reset values
	localparam logic [7:0]  BASE_RST      = 8'h00;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	// Host read answer when nothing matches
	localparam logic [7:0]  IDLE_RDATA    = 8'hff;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} hmd_host_req_t;

	typedef struct packed {
		logic [3:0] ext;
		logic       cd;
		logic       user;
		logic       input_full_flag;
		logic       output_full_flag;
	} hmd_status_t;
endpackage

// file: verilog/hmd_sync.sv
// Two-flop synchroniser for a bundle of inputs from outside the clock domain
`timescale 1ns/1ns
module hmd_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// file: verilog/hmd_mailbox.sv
// Host mailbox decode: three byte channels, channel-3 window and sixteen shared registers
// How it works
// - Channel 3 matches host address against base
// - Channel 3: base bit0 as zero, bit2 ignored
// - Shared window: base bit4 inverted, bits3-0 ignored
// - Channel 3 read: bit2 picks output or status
// - Shared enable bit gates host access to shared registers
// - Base registers reset zero, readable and writable
// - Host input write latches address bit2 flag
// - Matching host write stores input byte
// - Channels 1,2 fixed address; bit1 picks
// - Host read bit2 zero returns output byte
// - Host read bit2 one returns status
// - Status flags read-only; slave clears some
// - All status registers reset to zero
// - Sixteen shared bytes, both sides read/write
// - Slot 0 has host and slave copies
// - Each slot-0 copy written by one side
// - Slot-0 write arbitration recorded in flags
// - Command/data flag held in status bit3
// - Input full set by host, cleared by read
// - Output full set by slave write, cleared
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module hmd_mailbox (
	input  wire logic                  ref_clk_in,
	input  wire logic                  sys_rst_in,
	// Link side; inputs asynchronous to ref_clk_in, outputs registered on ref_clk_in
	input  wire logic                  lpc_clk_in,
	input  wire logic                  host_req_in,
	input  wire hmd_pkg::hmd_host_req_t host_cyc_in,
	output logic [7:0]                 host_rdata_out,
	output logic                       host_rvalid_out,
	// Slave register port
	input  wire logic [4:0]            reg_addr_in,
	input  wire logic [7:0]            reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic [7:0]                 reg_rdata_out
);
	localparam int NCH = 3;

	// Link synchronisation and host strobe
	hmd_pkg::hmd_host_req_t host_cyc;
	logic                   lclk_s;
	logic                   req_s;
	logic                   lclk_prev_q;
	logic                   host_stb;

	hmd_sync #(
		.W ($bits(hmd_pkg::hmd_host_req_t) + 2)
	) u_sync (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({lpc_clk_in, host_req_in, host_cyc_in}),
		.sync_out   ({lclk_s, req_s, host_cyc})
	);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			lclk_prev_q <= 1'b0;
		end else begin
			lclk_prev_q <= lclk_s;
		end
	end

	// One host cycle per rising link clock edge with request high
	assign host_stb = lclk_s & ~lclk_prev_q & req_s;

	// Configuration registers
	logic [7:0] base_high_q;
	logic [7:0] base_low_q;
	logic       ch3_en_q;
	logic [15:0] base;

	assign base = {base_high_q, base_low_q};

	// Host address decode
	logic [15:0] ha;
	logic        h_fix;
	logic        h_c3;
	logic        h_tw;
	logic [1:0]  h_ch;
	logic [3:0]  h_slot;
	logic        h_ch_hit;

	assign ha     = host_cyc.addr;
	assign h_slot = ha[3:0];
	assign h_fix  = host_stb && ha[15:4] == hmd_pkg::FIXED_HI && !ha[3] && !ha[0];
	assign h_c3   = host_stb && ch3_en_q && !h_fix
		&& ha[15:3] == base[15:3] && ha[1] == base[1] && !ha[0];
	assign h_tw   = host_stb && ch3_en_q && base_low_q[hmd_pkg::SHR_EN_BIT] && !h_fix && !h_c3
		&& ha[15:5] == base[15:5] && ha[4] == ~base[4];
	assign h_ch     = h_fix ? {1'b0, ha[1]} : 2'd2;
	assign h_ch_hit = h_fix | h_c3;

	// Slave address decode
	logic [1:0] s_ch;
	logic [1:0] s_sub;
	logic       s_ch_hit;
	logic       s_tw;
	logic [3:0] s_slot;

	assign s_ch     = reg_addr_in[3:2];
	assign s_sub    = reg_addr_in[1:0];
	assign s_ch_hit = reg_addr_in <= hmd_pkg::OFF_CH_LAST;
	assign s_tw     = reg_addr_in >= hmd_pkg::OFF_SHARED;
	assign s_slot   = reg_addr_in[3:0];

	// Channel storage and flags
	logic [7:0]  in_byte_q  [NCH];
	logic [7:0]  out_byte_q [NCH];
	logic [NCH-1:0] cd_q;
	logic [NCH-1:0] ibf_q;
	logic [NCH-1:0] obf_q;
	logic        host_own_q;
	logic        slave_own_q;
	hmd_pkg::hmd_status_t status [NCH];

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			status[i].ext  = 4'h0;
			status[i].cd   = cd_q[i];
			status[i].user = 1'b0;
			status[i].input_full_flag  = ibf_q[i];
			status[i].output_full_flag  = obf_q[i];
		end
		status[NCH-1].ext = {1'b0, slave_own_q, 1'b0, host_own_q};
	end

	// Configuration writes
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			base_high_q <= hmd_pkg::BASE_RST;
			base_low_q  <= hmd_pkg::BASE_RST;
			ch3_en_q    <= 1'b0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == hmd_pkg::OFF_BASE_HIGH) begin
				base_high_q <= reg_wdata_in;
			end
			if (reg_addr_in == hmd_pkg::OFF_BASE_LOW) begin
				base_low_q <= reg_wdata_in;
			end
			if (reg_addr_in == hmd_pkg::OFF_CTRL) begin
				ch3_en_q <= reg_wdata_in[hmd_pkg::CH3_EN_BIT];
			end
		end
	end

	// Input bytes, no reset
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < NCH; i++) begin
			if (h_ch_hit && host_cyc.wr && h_ch == 2'(i)) begin
				in_byte_q[i] <= host_cyc.data;
			end
		end
	end

	// Output bytes, no reset
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < NCH; i++) begin
			if (reg_wr_in && s_ch_hit && s_ch == 2'(i) && s_sub == hmd_pkg::SUB_OUT_BYTE) begin
				out_byte_q[i] <= reg_wdata_in;
			end
		end
	end

	// Per-channel flag events from both sides
	logic [NCH-1:0] h_wr_in;
	logic [NCH-1:0] h_rd_out;
	logic [NCH-1:0] s_rd_in;
	logic [NCH-1:0] s_wr_out;
	logic [NCH-1:0] s_clr_obf;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			h_wr_in[i]   = h_ch_hit && host_cyc.wr && h_ch == 2'(i);
			h_rd_out[i]  = h_ch_hit && !host_cyc.wr && !ha[hmd_pkg::SEL_BIT] && h_ch == 2'(i);
			s_rd_in[i]   = reg_rd_in && s_ch_hit && s_ch == 2'(i) && s_sub == hmd_pkg::SUB_IN_BYTE;
			s_wr_out[i]  = reg_wr_in && s_ch_hit && s_ch == 2'(i) && s_sub == hmd_pkg::SUB_OUT_BYTE;
			s_clr_obf[i] = reg_wr_in && s_ch_hit && s_ch == 2'(i) && s_sub == hmd_pkg::SUB_STATUS
				&& !reg_wdata_in[hmd_pkg::OBF_BIT];
		end
	end

	// Status flags; a set in the same cycle as a clear wins
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cd_q  <= '0;
			ibf_q <= '0;
			obf_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (h_wr_in[i]) begin
					cd_q[i] <= ha[hmd_pkg::SEL_BIT];
				end
				ibf_q[i] <= h_wr_in[i] | (ibf_q[i] & ~s_rd_in[i]);
				obf_q[i] <= s_wr_out[i] | (obf_q[i] & ~(h_rd_out[i] | s_clr_obf[i]));
			end
		end
	end

	// Shared registers and slot-0 arbitration
	logic [7:0] shared_q [16];
	logic [7:0] slot0_slave_q;
	logic       h_tw_wr;
	logic       s_tw_wr;
	logic       host_ok;
	logic       slave_ok;
	logic       s_wr_str3;

	assign h_tw_wr   = h_tw && host_cyc.wr;
	assign s_tw_wr   = reg_wr_in && s_tw;
	assign host_ok   = h_tw_wr && h_slot == 4'h0 && !slave_own_q;
	assign slave_ok  = s_tw_wr && s_slot == 4'h0 && !host_own_q && !host_ok;
	assign s_wr_str3 = reg_wr_in && s_ch_hit && s_ch == 2'd2 && s_sub == hmd_pkg::SUB_STATUS;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			host_own_q  <= 1'b0;
			slave_own_q <= 1'b0;
		end else begin
			host_own_q  <= host_ok
				| (host_own_q & ~(s_wr_str3 & ~reg_wdata_in[hmd_pkg::HOST_OWN_BIT]));
			slave_own_q <= slave_ok
				| (slave_own_q & ~(s_wr_str3 & ~reg_wdata_in[hmd_pkg::SLAVE_OWN_BIT]));
		end
	end

	// Shared data, no reset; host wins a same-cycle write to one slot
	always_ff @(posedge ref_clk_in) begin
		if (host_ok) begin
			shared_q[0] <= host_cyc.data;
		end
		if (slave_ok) begin
			slot0_slave_q <= reg_wdata_in;
		end
		for (int j = 1; j < 16; j++) begin
			if (h_tw_wr && h_slot == 4'(j)) begin
				shared_q[j] <= host_cyc.data;
			end else if (s_tw_wr && s_slot == 4'(j)) begin
				shared_q[j] <= reg_wdata_in;
			end
		end
	end

	// Host read answer
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			host_rdata_out  <= hmd_pkg::IDLE_RDATA;
			host_rvalid_out <= 1'b0;
		end else begin
			host_rvalid_out <= host_stb && !host_cyc.wr;
			if (host_stb && !host_cyc.wr) begin
				if (h_ch_hit) begin
					host_rdata_out <= ha[hmd_pkg::SEL_BIT] ? status[h_ch] : out_byte_q[h_ch];
				end else if (h_tw) begin
					host_rdata_out <= (h_slot == 4'h0) ? slot0_slave_q : shared_q[h_slot];
				end else begin
					host_rdata_out <= hmd_pkg::IDLE_RDATA;
				end
			end
		end
	end

	// Slave read answer, one cycle after the strobe
	logic [7:0] s_rdata;

	always_comb begin
		s_rdata = 8'h00;
		if (s_ch_hit) begin
			case (s_sub)
				hmd_pkg::SUB_IN_BYTE:  s_rdata = in_byte_q[s_ch];
				hmd_pkg::SUB_OUT_BYTE: s_rdata = out_byte_q[s_ch];
				hmd_pkg::SUB_STATUS:   s_rdata = status[s_ch];
				default:               s_rdata = 8'h00;
			endcase
		end else if (s_tw) begin
			s_rdata = shared_q[s_slot];
		end else if (reg_addr_in == hmd_pkg::OFF_BASE_HIGH) begin
			s_rdata = base_high_q;
		end else if (reg_addr_in == hmd_pkg::OFF_BASE_LOW) begin
			s_rdata = base_low_q;
		end else if (reg_addr_in == hmd_pkg::OFF_CTRL) begin
			s_rdata = {7'h00, ch3_en_q};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= s_rdata;
		end
	end
endmodule

// file: tb/hmd_mailbox_assertions.sv
// Port checks for the host mailbox decode block
`timescale 1ns/1ns
module hmd_mailbox_assertions (
	input logic                   ref_clk_in,
	input logic                   sys_rst_in,
	input logic                   lpc_clk_in,
	input logic                   host_req_in,
	input hmd_pkg::hmd_host_req_t host_cyc_in,
	input logic [7:0]             host_rdata_out,
	input logic                   host_rvalid_out,
	input logic [4:0]             reg_addr_in,
	input logic [7:0]             reg_wdata_in,
	input logic                   reg_wr_in,
	input logic                   reg_rd_in,
	input logic [7:0]             reg_rdata_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_pulse; host_rvalid_out |=> !host_rvalid_out; endproperty
	a_pulse: assert property (p_pulse) else $error("rvalid too long");
	property p_hold; !$past(reg_rd_in) |-> $stable(reg_rdata_out); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; reg_rd_in && reg_addr_in == 5'h0f |=> reg_rdata_out == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_base; reg_wr_in && reg_addr_in == 5'h0c ##1 reg_rd_in && reg_addr_in == 5'h0c
		|=> reg_rdata_out == $past(reg_wdata_in, 2); endproperty
	a_base: assert property (p_base) else $error("base readback");
	property p_obf; reg_wr_in && reg_addr_in == 5'h01 ##1 reg_rd_in && reg_addr_in == 5'h02
		|=> reg_rdata_out[0]; endproperty
	a_obf: assert property (p_obf) else $error("output full not set");
	property p_clr; reg_wr_in && reg_addr_in == 5'h0a && reg_wdata_in == 8'h00 ##1 reg_rd_in
		&& reg_addr_in == 5'h0a |=> !reg_rdata_out[4] && !reg_rdata_out[0]; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_ibf; reg_rd_in && reg_addr_in == 5'h00 ##2 reg_rd_in && reg_addr_in == 5'h02
		|=> !reg_rdata_out[1]; endproperty
	a_ibf: assert property (p_ibf) else $error("input full not cleared");
	property p_ans; $rose(lpc_clk_in) && host_req_in && !host_cyc_in.wr |-> ##[1:8] host_rvalid_out; endproperty
	a_ans: assert property (p_ans) else $error("no host answer");
endmodule
bind hmd_mailbox hmd_mailbox_assertions i_hmd_mailbox_assertions (.*);

// file: tb/hmd_host_model.sv
// Host model: one I/O cycle per link clock rising edge, clock idle low
`timescale 1ns/1ns
module hmd_host_model (
	input  logic                   ref_clk_in,
	input  logic                   rvalid_in,
	input  logic [7:0]             rdata_in,
	output logic                   lpc_clk_out,
	output logic                   req_out,
	output hmd_pkg::hmd_host_req_t cyc_out
);
	initial begin
		lpc_clk_out = 1'b0;
		req_out = 1'b0;
		cyc_out = '0;
	end
	task io(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
		r = 'x;
		@(posedge ref_clk_in);
		req_out <= 1'b1;
		cyc_out <= '{w, a, d};
		repeat (4) @(posedge ref_clk_in);
		lpc_clk_out <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			@(posedge ref_clk_in);
			#1;
			if (rvalid_in === 1'b1)
				r = rdata_in;
			if (i == 3)
				lpc_clk_out <= 1'b0;
			// Released lines show the inverse
			if (i == 6)
				{req_out, cyc_out} <= ~{req_out, cyc_out};
		end
	endtask
endmodule

// file: tb/test_lpc_host_mailbox_decode.sv
// Bench for the host mailbox decode block
`timescale 1ns/1ns
module test_lpc_host_mailbox_decode;
	logic ref_clk_in, sys_rst_in, lpc_clk_in, host_req_in, host_rvalid_out, reg_wr_in, reg_rd_in;
	logic [4:0] reg_addr_in;
	logic [7:0] reg_wdata_in, host_rdata_out, reg_rdata_out, r;
	hmd_pkg::hmd_host_req_t host_cyc_in;
	int num_errors = 0;
	int num_checks = 0;
	hmd_mailbox i_hmd_mailbox (.*);
	hmd_host_model i_hmd_host_model (.ref_clk_in, .rvalid_in(host_rvalid_out), .rdata_in(host_rdata_out),
		.lpc_clk_out(lpc_clk_in), .req_out(host_req_in), .cyc_out(host_cyc_in));
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	task chk(input string n, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, rd, input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= w;
		reg_rd_in <= rd;
		reg_addr_in <= a;
		reg_wdata_in <= d;
	endtask
	task sw(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	task sr(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1;
		chk("slave read", reg_rdata_out, e);
	endtask
	task hw(input logic [15:0] a, input logic [7:0] d);
		i_hmd_host_model.io(1'b1, a, d, r);
	endtask
	task hr(input logic [15:0] a, input logic [7:0] e);
		i_hmd_host_model.io(1'b0, a, 8'h00, r);
		chk("host read", r, e);
	endtask
	task t_reset;
		sr(5'h0c, 8'h00);
		sr(5'h0d, 8'h00);
		for (int c = 0; c < 3; c++)
			sr(5'(4 * c + 2), 8'h00);
		sw(5'h0f, 8'h5a);
		sr(5'h0f, 8'h00);
		$display("reset test done");
	endtask
	task t_fixed;
		logic [15:0] a;
		logic [4:0]  s;
		logic [7:0]  cd;
		for (int c = 0; c < 2; c++) begin
			a = 16'h0060 | 16'(2 * c);
			s = 5'(4 * c);
			cd = 8'(8 * (1 - c));
			// Channel 1 gets a command, channel 2 data
			hw(a | 16'(4 * (1 - c)), 8'h3c + 8'(c));
			sr(s + 5'h02, cd | 8'h02);
			sr(s, 8'h3c + 8'(c));
			sr(s + 5'h02, cd);
			bus(1'b1, 1'b0, s + 5'h01, 8'hc0 + 8'(c));
			sr(s + 5'h02, cd | 8'h01);
			hr(a | 16'h0004, cd | 8'h01);
			hr(a, 8'hc0 + 8'(c));
			hr(a | 16'h0004, cd);
		end
		$display("fixed channel test done");
	endtask
	task t_ch3;
		bus(1'b1, 1'b0, 5'h0c, 8'h12);
		sr(5'h0c, 8'h12);
		sw(5'h0d, 8'ha7);
		sr(5'h0d, 8'ha7);
		hw(16'h12a6, 8'h5a);
		sr(5'h0a, 8'h00);
		sw(5'h0e, 8'h01);
		hw(16'h12a6, 8'h5a);
		hw(16'h12a0, 8'h11);
		sr(5'h0a, 8'h0a);
		sr(5'h08, 8'h5a);
		sw(5'h09, 8'h3c);
		hr(16'h12a6, 8'h09);
		hr(16'h12a2, 8'h3c);
		sr(5'h0a, 8'h08);
		hw(16'h12b5, 8'h77);
		sr(5'h15, 8'h77);
		sw(5'h13, 8'h33);
		hr(16'h12b3, 8'h33);
		hw(16'h12b0, 8'hc1);
		sr(5'h10, 8'hc1);
		sw(5'h10, 8'h99);
		sr(5'h0a, 8'h18);
		bus(1'b1, 1'b0, 5'h0a, 8'h00);
		sr(5'h0a, 8'h08);
		sw(5'h10, 8'h99);
		sr(5'h0a, 8'h48);
		hr(16'h12b0, 8'h99);
		hw(16'h12b0, 8'h44);
		sr(5'h10, 8'hc1);
		sw(5'h0d, 8'ha6);
		hr(16'h12b3, 8'hff);
		sw(5'h0e, 8'h00);
		hr(16'h12a6, 8'hff);
		$display("channel 3 test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		sys_rst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 5'h00;
		reg_wdata_in = 8'h00;
		repeat (16) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		t_reset;
		t_fixed;
		t_ch3;
		stop_test;
	end
	initial begin
		#400000;
		num_errors++;
		stop_test;
	end
endmodule
